// File: core/ucip_pkg.sv
/*
 Shared constants and carrier types for the per-channel interrupt prioritiser.
 Assumes a single 100 MHz channel clock and an active-low asynchronous reset.
*/
package ucip_pkg;
    // ---------------------------------------------------------------
    // register offsets (A3..A0)
    // ---------------------------------------------------------------
    localparam logic [3:0] UCIP_OFS_ENABLE = 4'h1;
    localparam logic [3:0] UCIP_OFS_SOURCE = 4'h2;
    localparam logic [3:0] UCIP_OFS_LINE = 4'h5;
    localparam logic [3:0] UCIP_OFS_MODEM = 4'h6;
    localparam logic [7:0] UCIP_ENABLE_RESET = 8'h00;
    // ---------------------------------------------------------------
    // enable register fields
    // ---------------------------------------------------------------
    localparam int UCIP_EN_RX = 0;
    localparam int UCIP_EN_TX = 1;
    localparam int UCIP_EN_LINE = 2;
    localparam int UCIP_EN_MODEM = 3;
    localparam int UCIP_EN_XCHAR = 5;
    localparam int UCIP_EN_OUTPIN = 6;
    localparam int UCIP_EN_INPIN = 7;
    localparam logic [7:0] UCIP_EN_BASIC_MASK = 8'h0F;
    localparam logic [7:0] UCIP_EN_ENH_MASK = 8'hE0;
    // ---------------------------------------------------------------
    // source codes, bits 5..0
    // ---------------------------------------------------------------
    localparam logic [5:0] UCIP_SRC_LINE = 6'h06;
    localparam logic [5:0] UCIP_SRC_RX_READY_IRQ = 6'h04;
    localparam logic [5:0] UCIP_SRC_TIMEOUT = 6'h0C;
    localparam logic [5:0] UCIP_SRC_TX_READY_IRQ = 6'h02;
    localparam logic [5:0] UCIP_SRC_MODEM = 6'h00;
    localparam logic [5:0] UCIP_SRC_XCHAR = 6'h10;
    localparam logic [5:0] UCIP_SRC_FLOW = 6'h20;
    localparam logic [5:0] UCIP_SRC_NONE = 6'h01;
    // ---------------------------------------------------------------
    // timeout: 4 character times plus 12 bit times
    // ---------------------------------------------------------------
    localparam int UCIP_TMO_CHARS = 4;
    localparam int UCIP_TMO_BITS = 12;
    localparam int UCIP_CHAR_BITS = 10;
    localparam int UCIP_TMO_BIT_TIMES = UCIP_TMO_CHARS * UCIP_CHAR_BITS + UCIP_TMO_BITS;

    typedef enum logic [2:0] {
        UCIP_P_NONE = 3'b000,
        UCIP_P_LINE = 3'b001,
        UCIP_P_RX_READY_IRQ = 3'b010,
        UCIP_P_TIMEOUT = 3'b011,
        UCIP_P_TX_READY_IRQ = 3'b100,
        UCIP_P_MODEM = 3'b101,
        UCIP_P_XCHAR = 3'b110,
        UCIP_P_FLOW = 3'b111
    } ucip_prio_e;

    // register access strobes from the channel bus decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ucip_bus_s;

    // receive datapath state
    typedef struct packed {
        logic [6:0] level;
        logic [6:0] trigger;
        logic char_in;
        logic char_err;
        logic rx_idle;
        logic bit_tick;
    } ucip_rx_s;
endpackage

// File: core/ucip_timeout.sv
/*
 Receive idle timer: counts bit times while the receive line idles.
 Assumes bit_tick is a one-cycle pulse per bit time in the mclk domain.
*/
module ucip_timeout
    import ucip_pkg::*;
#(
    parameter int LIMIT = UCIP_TMO_BIT_TIMES
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic arm,
    input wire logic restart,
    input wire logic bit_tick,
    output logic expired
);
    localparam int CW = $clog2(LIMIT + 1);
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_expired;

    initial
    begin
        if (LIMIT < 1)
        begin
            $error("timeout limit must be positive");
        end
    end

    always_comb
    begin
        next_count = count;
        next_expired = expired;
        if (!arm || restart)
        begin
            next_count = '0;
            next_expired = 1'b0;
        end
        else if (bit_tick && !expired)
        begin
            if (count == CW'(LIMIT - 1))
            begin
                next_expired = 1'b1;
            end
            else
            begin
                next_count = count + CW'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= '0;
            expired <= 1'b0;
        end
        else
        begin
            count <= next_count;
            expired <= next_expired;
        end
    end
endmodule

// File: core/ucip_top.sv
/*
 Per-channel interrupt enable and prioritised source register of one UART channel.
 Assumes status inputs come from logic on mclk; flow pins arrive from outside and are synchronised here.
*/
// Functional notes
// (RULE_01) receive ready tracks FIFO level versus trigger
// (RULE_02) data-ready set on char, cleared empty
// (RULE_03) host polls with enable bits 0-3 clear
// (RULE_04) line status bit layout as documented
// (RULE_05) FIFO idle four chars plus twelve bits
// (RULE_06) non-FIFO ready when holding register full
// (RULE_07) direction control off: transmit follows bit 5
// (RULE_08) direction control on: transmit follows bit 6
// (RULE_09) receive error raises line interrupt immediately
// (RULE_10) enable 7:5 need unlock; bit 4 reserved
// (RULE_11) output flow pin rising edge interrupt
// (RULE_12) input flow pin rising edge interrupt
// (RULE_13) source read shows only highest pending
// (RULE_14) codes for priorities one to three
// (RULE_15) codes for priorities four to seven, none
// (RULE_16) modem deltas raise, modem read clears
// (RULE_17) xon/xoff/special raise; clear rules
// (RULE_18) line read and source read clears
// (RULE_19) receive ready and timeout clear by level
// (RULE_20) modem read clears flow-pin interrupts
// (RULE_21) wake flag set on wake, cleared word0
// (RULE_22) enabled pending mirrored to global word
// (RULE_23) bit 0 low while anything pending
// (RULE_24) bits 7:6 show FIFO enable
// (RULE_25) request is OR of enabled sources
module ucip_top
    import ucip_pkg::*;
#(
    parameter int FIFO_DEPTH = 64
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire ucip_pkg::ucip_bus_s bus,
    input wire ucip_pkg::ucip_rx_s rx,
    input wire logic fifo_en,
    input wire logic half_duplex_en,
    input wire logic [7:0] line_status,
    input wire logic [3:0] modem_delta,
    input wire logic enh_unlock,
    input wire logic auto_out_flow,
    input wire logic auto_in_flow,
    input wire logic flow_pin_sel,
    input wire logic rts_pin,
    input wire logic dtr_pin,
    input wire logic cts_pin,
    input wire logic dsr_pin,
    input wire logic xonoff_det,
    input wire logic special_det,
    input wire logic wake_event,
    input wire logic global_word0_rd,
    output logic [7:0] channel_irq_enable,
    output logic [7:0] channel_irq_source,
    output logic data_ready,
    output logic irq,
    output logic [6:0] global_pending,
    output logic wake_flag
);
    import ucip_pkg::*;

    initial
    begin
        if (FIFO_DEPTH < 1 || FIFO_DEPTH > 127)
        begin
            $error("fifo depth out of range");
        end
    end

    // ---------------------------------------------------------------
    // access strobes
    // ---------------------------------------------------------------
    logic wr_enable, rd_source, rd_line, rd_modem;
    assign wr_enable = bus.wr && bus.addr == UCIP_OFS_ENABLE;
    assign rd_source = bus.rd && bus.addr == UCIP_OFS_SOURCE;
    assign rd_line = bus.rd && bus.addr == UCIP_OFS_LINE;
    assign rd_modem = bus.rd && bus.addr == UCIP_OFS_MODEM;

    // ---------------------------------------------------------------
    // flow pin synchronisers
    // ---------------------------------------------------------------
    // all four pins synchronised before any select logic touches them
    logic [3:0] pin_s1, pin_s2, pin_s3;
    logic [3:0] pin_raw;
    assign pin_raw = {dsr_pin, cts_pin, dtr_pin, rts_pin};
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            pin_s3 <= 4'h0;
        end
        else
        begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end
    logic out_rise, in_rise;
    // select after the synchronisers, so a select change cannot fake an edge
    assign out_rise = (flow_pin_sel ? pin_s2[1] && !pin_s3[1] : pin_s2[0] && !pin_s3[0]) && auto_out_flow; // RULE_11
    assign in_rise = (flow_pin_sel ? pin_s2[3] && !pin_s3[3] : pin_s2[2] && !pin_s3[2]) && auto_in_flow; // RULE_12

    // ---------------------------------------------------------------
    // receive timeout
    // ---------------------------------------------------------------
    logic tmo_expired;
    logic tmo_arm;
    // below trigger with data present, FIFO mode only
    assign tmo_arm = fifo_en && rx.rx_idle && rx.level != 7'h00 && rx.level < rx.trigger; // RULE_05
    ucip_timeout #(.LIMIT(UCIP_TMO_BIT_TIMES)) u_tmo (
        .mclk(mclk),
        .rst_n(rst_n),
        .arm(tmo_arm),
        .restart(rx.char_in),
        .bit_tick(rx.bit_tick),
        .expired(tmo_expired)
    );

    // ---------------------------------------------------------------
    // sticky sources
    // ---------------------------------------------------------------
    logic line_p, modem_p, tx_p, xchar_p, xspec, flow_p, tmo_p;
    logic next_line_p, next_modem_p, next_tx_p, next_xchar_p, next_xspec, next_flow_p, next_tmo_p;
    logic [7:0] next_enable;
    logic next_wake, next_data_ready;
    logic tx_cond, tx_cond_d, next_tx_cond_d;
    logic rx_ready_irq;
    logic [6:0] pend;
    // hold the source sampled at read so the clear hits only what was shown
    ucip_prio_e shown;

    assign tx_cond = half_duplex_en ? line_status[6] : line_status[5]; // RULE_04 RULE_07 RULE_08
    assign rx_ready_irq = fifo_en ? (rx.level >= rx.trigger) : (rx.level != 7'h00); // RULE_01 RULE_06 RULE_19

    always_comb
    begin
        next_enable = channel_irq_enable;
        if (wr_enable)
        begin
            // unlocked bits keep old value when locked; bit 4 stays 0
            next_enable = (bus.wdata & UCIP_EN_BASIC_MASK)
                        | ((enh_unlock ? bus.wdata : channel_irq_enable) & UCIP_EN_ENH_MASK); // RULE_10
        end
        next_tx_cond_d = tx_cond;
        // set wins over clear on every flag
        next_line_p = (line_p && !rd_line) || (rx.char_err && |line_status[4:1]); // RULE_09 RULE_18
        next_modem_p = (modem_p && !rd_modem) || |modem_delta; // RULE_16
        next_tx_p = (tx_p && !(rd_source && shown == UCIP_P_TX_READY_IRQ) && tx_cond)
                  || (tx_cond && !tx_cond_d); // RULE_18
        next_xspec = xspec;
        next_xchar_p = xchar_p;
        if ((rd_source && shown == UCIP_P_XCHAR) || (xspec && rx.char_in))
        begin
            next_xchar_p = 1'b0; // RULE_17
            next_xspec = 1'b0;
        end
        if (xonoff_det || special_det)
        begin
            next_xchar_p = 1'b1; // RULE_17
            next_xspec = special_det && !xonoff_det;
        end
        // each pin raises only under its own enable bit
        next_flow_p = (flow_p && !rd_modem) || (out_rise && channel_irq_enable[UCIP_EN_OUTPIN])
                    || (in_rise && channel_irq_enable[UCIP_EN_INPIN]); // RULE_20
        // timeout holds until the FIFO is empty
        next_tmo_p = (tmo_p && fifo_en && rx.level != 7'h00) || tmo_expired; // RULE_19
        next_wake = (wake_flag && !global_word0_rd) || wake_event; // RULE_21
        next_data_ready = (data_ready && rx.level != 7'h00) || rx.char_in; // RULE_02 RULE_04
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            channel_irq_enable <= UCIP_ENABLE_RESET;
            line_p <= 1'b0;
            modem_p <= 1'b0;
            tx_p <= 1'b0;
            tx_cond_d <= 1'b0;
            xchar_p <= 1'b0;
            xspec <= 1'b0;
            flow_p <= 1'b0;
            tmo_p <= 1'b0;
            wake_flag <= 1'b0;
            data_ready <= 1'b0;
        end
        else
        begin
            channel_irq_enable <= next_enable;
            line_p <= next_line_p;
            modem_p <= next_modem_p;
            tx_p <= next_tx_p;
            tx_cond_d <= next_tx_cond_d;
            xchar_p <= next_xchar_p;
            xspec <= next_xspec;
            flow_p <= next_flow_p;
            tmo_p <= next_tmo_p;
            wake_flag <= next_wake;
            data_ready <= next_data_ready;
        end
    end

    // ---------------------------------------------------------------
    // masking and priority
    // ---------------------------------------------------------------
    // polled mode simply leaves bits 0-3 clear so line, receive, timeout, transmit and modem never reach pend
    assign pend = {flow_p && (channel_irq_enable[UCIP_EN_OUTPIN] || channel_irq_enable[UCIP_EN_INPIN]),
                   xchar_p && channel_irq_enable[UCIP_EN_XCHAR],
                   modem_p && channel_irq_enable[UCIP_EN_MODEM],
                   tx_p && channel_irq_enable[UCIP_EN_TX],
                   tmo_p && channel_irq_enable[UCIP_EN_RX],
                   rx_ready_irq && channel_irq_enable[UCIP_EN_RX],
                   line_p && channel_irq_enable[UCIP_EN_LINE]}; // RULE_03 RULE_25

    ucip_prio_e top, next_shown;
    logic [5:0] top_code;
    always_comb
    begin
        top = UCIP_P_NONE;
        for (int i = 6; i >= 0; i--)
        begin
            if (pend[i])
            begin
                top = ucip_prio_e'(3'(i + 1)); // RULE_13
            end
        end
        unique case (top)
            UCIP_P_LINE: top_code = UCIP_SRC_LINE; // RULE_14
            UCIP_P_RX_READY_IRQ: top_code = UCIP_SRC_RX_READY_IRQ;
            UCIP_P_TIMEOUT: top_code = UCIP_SRC_TIMEOUT;
            UCIP_P_TX_READY_IRQ: top_code = UCIP_SRC_TX_READY_IRQ; // RULE_15
            UCIP_P_MODEM: top_code = UCIP_SRC_MODEM;
            UCIP_P_XCHAR: top_code = UCIP_SRC_XCHAR;
            UCIP_P_FLOW: top_code = UCIP_SRC_FLOW;
            UCIP_P_NONE: top_code = UCIP_SRC_NONE; // RULE_23
        endcase
        next_shown = top;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            channel_irq_source <= {2'b00, UCIP_SRC_NONE};
            shown <= UCIP_P_NONE;
            irq <= 1'b0;
            global_pending <= 7'h00;
        end
        else
        begin
            channel_irq_source <= {{2{fifo_en}}, top_code}; // RULE_24
            shown <= next_shown;
            irq <= |pend; // RULE_25
            global_pending <= pend; // RULE_22
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_reserved_bit;
        @(posedge mclk) disable iff (!rst_n) channel_irq_enable[4] == 1'b0;
    endproperty
    a_reserved_bit: assert property (p_reserved_bit) else $error("reserved enable bit set"); // RULE_10

    property p_locked_write;
        @(posedge mclk) disable iff (!rst_n) (wr_enable && !enh_unlock)
            |=> channel_irq_enable[7:5] == $past(channel_irq_enable[7:5]);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("locked enable bits changed"); // RULE_10

    property p_none_code;
        @(posedge mclk) disable iff (!rst_n) (pend == 7'h00) |=> channel_irq_source[5:0] == 6'h01;
    endproperty
    a_none_code: assert property (p_none_code) else $error("idle code wrong"); // RULE_23

    property p_line_top;
        @(posedge mclk) disable iff (!rst_n) pend[0] |=> channel_irq_source[5:0] == 6'h06;
    endproperty
    a_line_top: assert property (p_line_top) else $error("line status not top"); // RULE_14

    property p_fifo_bits;
        @(posedge mclk) disable iff (!rst_n) 1'b1 |=> channel_irq_source[7:6] == {2{$past(fifo_en)}};
    endproperty
    a_fifo_bits: assert property (p_fifo_bits) else $error("fifo bits wrong"); // RULE_24

    property p_modem_clear;
        @(posedge mclk) disable iff (!rst_n) (rd_modem && modem_delta == 4'h0) |=> !modem_p;
    endproperty
    a_modem_clear: assert property (p_modem_clear) else $error("modem not cleared"); // RULE_16

    property p_line_set;
        @(posedge mclk) disable iff (!rst_n) (rx.char_err && line_status[1]) |=> line_p;
    endproperty
    a_line_set: assert property (p_line_set) else $error("line error missed"); // RULE_09

    property p_irq_or;
        @(posedge mclk) disable iff (!rst_n) 1'b1 |=> irq == ($past(pend) != 7'h00);
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq not OR"); // RULE_25

    property p_wake;
        @(posedge mclk) disable iff (!rst_n) wake_event |=> wake_flag;
    endproperty
    a_wake: assert property (p_wake) else $error("wake lost"); // RULE_21

    c_line: cover property (@(posedge mclk) disable iff (!rst_n) pend[0] && pend[3]);
    c_tmo: cover property (@(posedge mclk) disable iff (!rst_n) tmo_expired);
    c_flow: cover property (@(posedge mclk) disable iff (!rst_n) pend[6]);
endmodule

// File: bench/ucip_host_model.sv
/*
 Host software model: issues register writes and reads as one-cycle strobes.
 Assumes the bench calls its tasks hierarchically, in the mclk domain.
*/
module ucip_host_model
(
    input wire logic mclk,
    output ucip_pkg::ucip_bus_s bus
);
    timeunit 1ns;
    timeprecision 1ps;
    import ucip_pkg::*;

    initial bus = '0;

    // ------------------------------------------------------------
    // register access
    // ------------------------------------------------------------
    // idle address and data inverted so a stale value never matches
    task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge mclk);
        bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // polled mode keeps FIFOs on, drops enable bits 0-3
    task automatic go_polled(input logic [7:0] cur);
        access(1'b1, UCIP_OFS_ENABLE, cur & ~UCIP_EN_BASIC_MASK);
    endtask
endmodule

// File: bench/tb.sv
/*
 Self-checking bench for the channel interrupt prioritiser.
 Assumes a host model on the strobe bus and the status inputs driven here.
*/
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ucip_pkg::*;

    logic mclk = 1'b0;
    logic rst_n;
    ucip_bus_s bus;
    ucip_rx_s rx;
    logic fifo_en, half_duplex_en, enh_unlock, auto_out_flow, auto_in_flow, flow_pin_sel;
    logic rts_pin, dtr_pin, cts_pin, dsr_pin, xonoff_det, special_det, wake_event, global_word0_rd;
    logic [7:0] line_status;
    logic [3:0] modem_delta;
    logic [7:0] en;
    logic [7:0] src;
    logic data_ready, irq, wake_flag;
    logic [6:0] gp;
    int fails = 0;
    int num_checks = 0;

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    ucip_host_model i_ucip_host_model (.mclk(mclk), .bus(bus));

    ucip_top i_ucip_top (
        .mclk(mclk), .rst_n(rst_n), .bus(bus), .rx(rx), .fifo_en(fifo_en),
        .half_duplex_en(half_duplex_en), .line_status(line_status), .modem_delta(modem_delta),
        .enh_unlock(enh_unlock), .auto_out_flow(auto_out_flow), .auto_in_flow(auto_in_flow),
        .flow_pin_sel(flow_pin_sel), .rts_pin(rts_pin), .dtr_pin(dtr_pin), .cts_pin(cts_pin),
        .dsr_pin(dsr_pin), .xonoff_det(xonoff_det), .special_det(special_det),
        .wake_event(wake_event), .global_word0_rd(global_word0_rd),
        .channel_irq_enable(en), .channel_irq_source(src), .data_ready(data_ready),
        .irq(irq), .global_pending(gp), .wake_flag(wake_flag)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // two cycles from cause to output, one spare
    task automatic src_is(input logic [5:0] code);
        cyc(3);
        chk(src, {fifo_en, fifo_en, code}, "source");
        chk({7'h00, irq}, {7'h00, code != UCIP_SRC_NONE}, "irq");
    endtask

    task automatic wr_en(input logic [7:0] v);
        i_ucip_host_model.access(1'b1, UCIP_OFS_ENABLE, v);
        cyc(1);
    endtask

    task automatic rd(input logic [3:0] a);
        i_ucip_host_model.access(1'b0, a, 8'h00);
    endtask

    task automatic done(input string name);
        $display("test %s finished, %0d mismatches so far", name, fails);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        cyc(1);
        chk(en, 8'h00, "enable reset");
        chk(src, 8'h01, "source reset");
        chk({gp, irq}, 8'h00, "pending reset");
        chk({6'h00, data_ready, wake_flag}, 8'h00, "flags reset");
        done("reset");
    endtask

    task automatic t_enable;
        wr_en(8'hFF);
        chk(en, 8'h0F, "locked write");
        enh_unlock <= 1'b1;
        wr_en(8'hFF);
        chk(en, 8'hEF, "unlocked write");
        wr_en(8'h00);
        done("enable");
    endtask

    task automatic t_line;
        fifo_en <= 1'b1;
        wr_en(8'h05);
        @(posedge mclk);
        rx.level <= 7'h08;
        rx.trigger <= 7'h08;
        rx.char_err <= 1'b1;
        line_status <= 8'h02;
        @(posedge mclk);
        rx.char_err <= 1'b0;
        src_is(UCIP_SRC_LINE);
        chk({6'h00, gp[1:0]}, 8'h03, "global pending");
        rd(UCIP_OFS_LINE);
        src_is(UCIP_SRC_RX_READY_IRQ);
        rx.level <= 7'h07;
        src_is(UCIP_SRC_NONE);
        @(posedge mclk);
        rx.char_in <= 1'b1;
        @(posedge mclk);
        rx.char_in <= 1'b0;
        cyc(3);
        chk({7'h00, data_ready}, 8'h01, "data ready set");
        rx.level <= 7'h00;
        cyc(3);
        chk({7'h00, data_ready}, 8'h00, "data ready clear");
        i_ucip_host_model.go_polled(en);
        @(posedge mclk);
        rx.char_err <= 1'b1;
        @(posedge mclk);
        rx.char_err <= 1'b0;
        src_is(UCIP_SRC_NONE);
        rd(UCIP_OFS_LINE);
        line_status <= 8'h00;
        done("line");
    endtask

    task automatic t_tx;
        wr_en(8'h02);
        line_status <= 8'h20;
        src_is(UCIP_SRC_TX_READY_IRQ);
        rd(UCIP_OFS_SOURCE);
        src_is(UCIP_SRC_NONE);
        half_duplex_en <= 1'b1;
        line_status <= 8'h00;
        cyc(1);
        line_status <= 8'h20;
        src_is(UCIP_SRC_NONE);
        line_status <= 8'h60;
        src_is(UCIP_SRC_TX_READY_IRQ);
        rd(UCIP_OFS_SOURCE);
        src_is(UCIP_SRC_NONE);
        line_status <= 8'h00;
        done("transmit");
    endtask

    task automatic t_modem_xchar;
        wr_en(8'h08);
        @(posedge mclk);
        modem_delta <= 4'h4;
        @(posedge mclk);
        modem_delta <= 4'h0;
        src_is(UCIP_SRC_MODEM);
        rd(UCIP_OFS_MODEM);
        src_is(UCIP_SRC_NONE);
        wr_en(8'h20);
        @(posedge mclk);
        xonoff_det <= 1'b1;
        @(posedge mclk);
        xonoff_det <= 1'b0;
        src_is(UCIP_SRC_XCHAR);
        rd(UCIP_OFS_SOURCE);
        src_is(UCIP_SRC_NONE);
        @(posedge mclk);
        special_det <= 1'b1;
        @(posedge mclk);
        special_det <= 1'b0;
        src_is(UCIP_SRC_XCHAR);
        @(posedge mclk);
        rx.char_in <= 1'b1;
        @(posedge mclk);
        rx.char_in <= 1'b0;
        src_is(UCIP_SRC_NONE);
        done("modem and xchar");
    endtask

    task automatic t_flow;
        wr_en(8'h40);
        auto_out_flow <= 1'b1;
        rts_pin <= 1'b1;
        cyc(2);
        src_is(UCIP_SRC_FLOW);
        chk({1'b0, gp}, 8'h40, "global flow");
        rd(UCIP_OFS_MODEM);
        src_is(UCIP_SRC_NONE);
        wr_en(8'h80);
        auto_in_flow <= 1'b1;
        flow_pin_sel <= 1'b1;
        dsr_pin <= 1'b1;
        cyc(2);
        src_is(UCIP_SRC_FLOW);
        rd(UCIP_OFS_MODEM);
        src_is(UCIP_SRC_NONE);
        done("flow pins");
    endtask

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            rx.bit_tick <= 1'b1;
            @(posedge mclk);
            rx.bit_tick <= 1'b0;
        end
    endtask

    task automatic t_timeout;
        wr_en(8'h01);
        rx.level <= 7'h01;
        rx.rx_idle <= 1'b1;
        ticks(UCIP_TMO_BIT_TIMES - 4);
        src_is(UCIP_SRC_NONE);
        ticks(8);
        src_is(UCIP_SRC_TIMEOUT);
        chk({1'b0, gp}, 8'h04, "global timeout");
        rx.level <= 7'h00;
        src_is(UCIP_SRC_NONE);
        done("timeout");
    endtask

    task automatic t_wake_nofifo;
        @(posedge mclk);
        wake_event <= 1'b1;
        @(posedge mclk);
        wake_event <= 1'b0;
        cyc(3);
        chk({7'h00, wake_flag}, 8'h01, "wake set");
        global_word0_rd <= 1'b1;
        @(posedge mclk);
        global_word0_rd <= 1'b0;
        cyc(3);
        chk({7'h00, wake_flag}, 8'h00, "wake clear");
        fifo_en <= 1'b0;
        rx.level <= 7'h01;
        src_is(UCIP_SRC_RX_READY_IRQ);
        // second reset in mid-run: enables and source return to idle
        @(posedge mclk);
        rst_n <= 1'b0;
        cyc(2);
        chk(en, 8'h00, "enable mid reset");
        chk(src, 8'h01, "source mid reset");
        @(posedge mclk);
        rst_n <= 1'b1;
        src_is(UCIP_SRC_NONE);
        done("wake and non-fifo");
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        rx = '0;
        {fifo_en, half_duplex_en, enh_unlock, auto_out_flow, auto_in_flow, flow_pin_sel} = '0;
        {rts_pin, dtr_pin, cts_pin, dsr_pin, xonoff_det, special_det, wake_event, global_word0_rd} = '0;
        line_status = 8'h00;
        modem_delta = 4'h0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_enable();
        t_line();
        t_tx();
        t_modem_xchar();
        t_flow();
        t_timeout();
        t_wake_nofifo();
        tally_and_finish();
    end

    // whole run is under 300 cycles; about seventy times that is a hang
    initial
    begin
        #200us;
        fails++;
        tally_and_finish();
    end
endmodule
